// >>> pio_pkg.sv
// package: register map, reset values, mode codes and carriers for the parallel i/o ports
package pio_pkg;

    localparam int unsigned PIO_WIDTH = 8;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] PIO_IDX_P1_DIR   = 8'hb0;
    localparam logic [7:0] PIO_IDX_P2_DIR   = 8'hb1;
    localparam logic [7:0] PIO_IDX_P1_LATCH = 8'hb2;
    localparam logic [7:0] PIO_IDX_P2_LATCH = 8'hb3;
    localparam logic [7:0] PIO_IDX_P3_PULL  = 8'haf;
    localparam logic [7:0] PIO_IDX_P1_PINS  = 8'hbc;
    localparam logic [7:0] PIO_IDX_P2_PINS  = 8'hbd;
    localparam logic [7:0] PIO_IDX_MODE     = 8'hbe;

    // ----------------------------------------------------------------
    // reset and read-back values
    // ----------------------------------------------------------------
    localparam logic [7:0]  PIO_RST_LATCH    = 8'h00;
    localparam logic [7:0]  PIO_RST_PULL     = 8'h00;
    localparam logic [7:0]  PIO_RST_DIR_LOW  = 8'h00;
    localparam logic [7:0]  PIO_RST_DIR_HIGH = 8'hff;
    localparam logic [7:0]  PIO_RD_WO        = 8'hff;
    localparam logic [31:0] PIO_RD_NONE      = 32'h0000_0000;

    // ----------------------------------------------------------------
    // operating mode codes on the mode straps
    // ----------------------------------------------------------------
    localparam logic [1:0] PIO_MODE_1 = 2'h1;

    // ----------------------------------------------------------------
    // ahb transfer type bits
    // ----------------------------------------------------------------
    localparam logic [1:0] PIO_HTRANS_NONSEQ = 2'h2;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pio_drive_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] idx;
    } pio_phase_t;

endpackage

// >>> pio_port_pins.sv
// module: per-pin drive and input sampling for one bidirectional 8-bit port
module pio_port_pins
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic [7:0]        dir,
    input  wire logic [7:0]        latch,
    input  wire logic [7:0]        pin_in,
    output pio_pkg::pio_drive_t    drive,
    output logic      [7:0]        pin_level
);
    import pio_pkg::*;

    logic [7:0] pin_q;

    // ----------------------------------------------------------------
    // pin drivers: a 0 direction bit leaves the pin floating as input
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < PIO_WIDTH; i++)
        begin : g_pin
            assign drive.oe[i]  = dir[i];
            assign drive.out[i] = latch[i] & dir[i];
        end
    endgenerate

    // pins are synchronous to hclk, so one stage of capture suffices
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pin_q <= 8'h00;
        else
            pin_q <= pin_in;
    end

    assign pin_level = pin_q;

endmodule // pio_port_pins

// >>> pio_ports.sv
// module: parallel i/o ports 1 to 3 with an ahb-lite register slave
//
// What this block does
// - port 3 has an 8-bit read/write pull-up select register whose bits all reset to 0.
// - each port 3 pull-up is on while its select bit is 1 and off while it is 0.
// - port 1 direction: 0 input, 1 output; all 1 and locked in mode 1, else reset 0, write-only.
// - port 1 has an 8-bit read/write output latch that resets to 0.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
module pio_ports
(
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic [1:0]        mode_sel,
    input  wire logic [7:0]        port1_in,
    output pio_pkg::pio_drive_t    port1_drive,
    input  wire logic [7:0]        port2_in,
    output pio_pkg::pio_drive_t    port2_drive,
    output logic      [7:0]        port3_pullup_en
);
    import pio_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pio_phase_t  phase_q;
    logic        rd_wait_q;
    logic [31:0] rdata_q;
    logic        init_q;
    logic [1:0]  mode_q;
    logic [7:0]  port1_direction_q;
    logic [7:0]  port2_direction_q;
    logic [7:0]  port1_output_latch_q;
    logic [7:0]  port2_output_latch_q;
    logic [7:0]  port3_pullup_select_q;
    logic [7:0]  p1_level;
    logic [7:0]  p2_level;

    // ----------------------------------------------------------------
    // address phase decode
    // ----------------------------------------------------------------
    wire        addr_take = hsel & hready & htrans[1];
    wire        addr_ok   = (haddr[31:10] == 22'h0) & (haddr[1:0] == 2'h0);
    wire [7:0]  addr_idx  = haddr[9:2];
    pio_phase_t phase_d;
    assign phase_d.valid = addr_take & addr_ok;
    assign phase_d.write = hwrite;
    assign phase_d.idx   = addr_idx;

    // ----------------------------------------------------------------
    // data phase strobes
    // ----------------------------------------------------------------
    wire wr_now   = phase_q.valid & phase_q.write;
    wire rd_now   = phase_q.valid & ~phase_q.write;
    wire mode_lck = (mode_q == PIO_MODE_1);

    wire wr_p1_dir   = wr_now & (phase_q.idx == PIO_IDX_P1_DIR) & ~mode_lck;
    wire wr_p2_dir   = wr_now & (phase_q.idx == PIO_IDX_P2_DIR) & ~mode_lck;
    wire wr_p1_latch = wr_now & (phase_q.idx == PIO_IDX_P1_LATCH);
    wire wr_p2_latch = wr_now & (phase_q.idx == PIO_IDX_P2_LATCH);
    wire wr_p3_pull  = wr_now & (phase_q.idx == PIO_IDX_P3_PULL);

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    // direction registers are write-only, so they never leak through here
    logic [31:0] rd_mux;
    always_comb
    begin
        case (phase_q.idx)
            PIO_IDX_P1_DIR:   rd_mux = {24'h0, PIO_RD_WO};
            PIO_IDX_P2_DIR:   rd_mux = {24'h0, PIO_RD_WO};
            PIO_IDX_P1_LATCH: rd_mux = {24'h0, port1_output_latch_q};
            PIO_IDX_P2_LATCH: rd_mux = {24'h0, port2_output_latch_q};
            PIO_IDX_P3_PULL:  rd_mux = {24'h0, port3_pullup_select_q};
            PIO_IDX_P1_PINS:  rd_mux = {24'h0, p1_level};
            PIO_IDX_P2_PINS:  rd_mux = {24'h0, p2_level};
            PIO_IDX_MODE:     rd_mux = {30'h0, mode_q};
            default:          rd_mux = PIO_RD_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------
    // one wait state on reads while rd_mux is registered into rdata_q, which drives hrdata
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q   <= '0;
            rd_wait_q <= 1'h0;
            rdata_q   <= PIO_RD_NONE;
        end
        else
        begin
            if (hreadyout)
                phase_q <= phase_d;
            rd_wait_q <= rd_now & ~rd_wait_q;
            if (rd_now & ~rd_wait_q)
                rdata_q <= rd_mux;
        end
    end

    assign hreadyout = ~(rd_now & ~rd_wait_q);
    assign hresp     = 1'h0;
    assign hrdata    = rdata_q;

    // ----------------------------------------------------------------
    // mode straps and direction initialisation
    // ----------------------------------------------------------------
    // the straps are caught on the first edge after reset release, so the
    // mode 1 all-output state appears one cycle after that release
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            init_q <= 1'h0;
            mode_q <= 2'h0;
        end
        else if (!init_q)
        begin
            init_q <= 1'h1;
            mode_q <= mode_sel;
        end
    end

    wire init_lck = ~init_q & (mode_sel == PIO_MODE_1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            port1_direction_q <= PIO_RST_DIR_LOW;
            port2_direction_q <= PIO_RST_DIR_LOW;
        end
        else
        begin
            if (init_lck)
                port1_direction_q <= PIO_RST_DIR_HIGH;
            else if (wr_p1_dir)
                port1_direction_q <= hwdata[7:0];
            if (init_lck)
                port2_direction_q <= PIO_RST_DIR_HIGH;
            else if (wr_p2_dir)
                port2_direction_q <= hwdata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // output latches and pull-up select
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            port1_output_latch_q  <= PIO_RST_LATCH;
            port2_output_latch_q  <= PIO_RST_LATCH;
            port3_pullup_select_q <= PIO_RST_PULL;
        end
        else
        begin
            if (wr_p1_latch)
                port1_output_latch_q <= hwdata[7:0];
            if (wr_p2_latch)
                port2_output_latch_q <= hwdata[7:0];
            if (wr_p3_pull)
                port3_pullup_select_q <= hwdata[7:0];
        end
    end

    assign port3_pullup_en = port3_pullup_select_q;

    // ----------------------------------------------------------------
    // pin logic
    // ----------------------------------------------------------------
    pio_port_pins u_port1
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .dir       (port1_direction_q),
        .latch     (port1_output_latch_q),
        .pin_in    (port1_in),
        .drive     (port1_drive),
        .pin_level (p1_level)
    );

    pio_port_pins u_port2
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .dir       (port2_direction_q),
        .latch     (port2_output_latch_q),
        .pin_in    (port2_in),
        .drive     (port2_drive),
        .pin_level (p2_level)
    );

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire hp_wr_p1_dir   = wr_now & (phase_q.idx == PIO_IDX_P1_DIR);
    wire hp_wr_p2_dir   = wr_now & (phase_q.idx == PIO_IDX_P2_DIR);
    wire hp_rd_p1_latch = rd_now & ~rd_wait_q & (phase_q.idx == PIO_IDX_P1_LATCH);
    wire hp_rd_p2_latch = rd_now & ~rd_wait_q & (phase_q.idx == PIO_IDX_P2_LATCH);
    wire hp_rd_pull     = rd_now & ~rd_wait_q & (phase_q.idx == PIO_IDX_P3_PULL);
    wire hp_rd_p1_pins  = rd_now & ~rd_wait_q & (phase_q.idx == PIO_IDX_P1_PINS);
    wire hp_rd_dir      = rd_now & ~rd_wait_q &
                          ((phase_q.idx == PIO_IDX_P1_DIR) | (phase_q.idx == PIO_IDX_P2_DIR));

    a_pullup_write: assert property (
        wr_p3_pull |=> port3_pullup_en == $past(hwdata[7:0]))
        else $error("pull-up select write not reflected on pull-up enables");

    a_pullup_hold: assert property (
        !wr_p3_pull |=> $stable(port3_pullup_en))
        else $error("pull-up enables changed without a select write");

    a_dir1_locked: assert property (
        init_q && mode_lck |-> port1_drive.oe == 8'hff)
        else $error("port 1 not all output in mode 1");

    a_dir1_write: assert property (
        hp_wr_p1_dir && !mode_lck |=> port1_drive.oe == $past(hwdata[7:0]))
        else $error("port 1 direction write lost");

    a_dir_input: assert property (
        (port1_drive.oe & port1_drive.out) == port1_drive.out)
        else $error("port 1 drives a pin that is set as input");

    a_latch1_write: assert property (
        wr_p1_latch |=> port1_output_latch_q == $past(hwdata[7:0]))
        else $error("port 1 latch write lost");

    a_latch1_read: assert property (
        hp_rd_p1_latch |=> hreadyout && hrdata == {24'h0, $past(port1_output_latch_q)})
        else $error("port 1 latch read returned the wrong value");

    a_dir2_behave: assert property (
        hp_wr_p2_dir |=> port2_drive.oe == (mode_lck ? 8'hff : $past(hwdata[7:0])))
        else $error("port 2 direction not handled like port 1");

    a_latch2_write: assert property (
        wr_p2_latch |=> port2_output_latch_q == $past(hwdata[7:0]))
        else $error("port 2 latch write lost");

    a_read_wait: assert property (
        rd_now && !rd_wait_q |-> !hreadyout ##1 hreadyout)
        else $error("read did not complete after one wait state");

    // ----------------------------------------------------------------
    // mode lock, read-back and reset assertions
    // ----------------------------------------------------------------
    // init_q rises one edge after release, once the mode 1 force has landed
    a_dir2_locked: assert property (
        init_q && mode_lck |-> port2_drive.oe == 8'hff)
        else $error("port 2 not all output in mode 1");

    a_dir_wo_read: assert property (
        hp_rd_dir |=> hrdata == {24'h0, PIO_RD_WO})
        else $error("write-only direction register leaked on a read");

    a_latch2_read: assert property (
        hp_rd_p2_latch |=> hrdata == {24'h0, $past(port2_output_latch_q)})
        else $error("port 2 latch read returned the wrong value");

    a_pullup_read: assert property (
        hp_rd_pull |=> hrdata == {24'h0, $past(port3_pullup_en)})
        else $error("pull-up select read returned the wrong value");

    a_pins_read: assert property (
        hp_rd_p1_pins |=> hrdata == {24'h0, $past(p1_level)})
        else $error("port 1 pin level read returned the wrong value");

    a_pullup_reset: assert property (
        $rose(init_q) |-> port3_pullup_en == PIO_RST_PULL)
        else $error("pull-up enables not off after reset");

    a_latch_reset: assert property (
        $rose(init_q) |-> port1_output_latch_q == PIO_RST_LATCH)
        else $error("port 1 latch not cleared after reset");

    a_dir_reset: assert property (
        $rose(init_q) |-> port1_drive.oe == (mode_lck ? PIO_RST_DIR_HIGH : PIO_RST_DIR_LOW))
        else $error("port 1 direction reset value wrong for the mode");

    a_dir2_reset: assert property (
        $rose(init_q) |-> port2_drive.oe == (mode_lck ? PIO_RST_DIR_HIGH : PIO_RST_DIR_LOW))
        else $error("port 2 direction reset value wrong for the mode");

    c_pullup_on: cover property (wr_p3_pull && hwdata[7:0] != 8'h00);
    c_dir_write: cover property (wr_p1_dir ##1 port1_drive.oe != 8'h00);
    c_latch_rd:  cover property (wr_p1_latch ##1 hp_rd_p1_latch);
    c_mode_lock: cover property (init_q && mode_lck && hp_wr_p1_dir);
    c_dir2_free: cover property (wr_p2_dir ##1 port2_drive.oe != 8'h00);

endmodule // pio_ports

// >>> pio_board.sv
// board model: the level on each port 1 and port 2 pin as the block sees it
module pio_board
(
    input  wire pio_pkg::pio_drive_t drive1,
    input  wire pio_pkg::pio_drive_t drive2,
    input  wire logic [7:0]          ext1,
    input  wire logic [7:0]          ext2,
    output logic      [7:0]          pin1,
    output logic      [7:0]          pin2
);
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;

    // a released pin shows the board's own level, a driven pin the block's level
    assign pin1 = (drive1.oe & drive1.out) | (~drive1.oe & ext1);
    assign pin2 = (drive2.oe & drive2.out) | (~drive2.oe & ext2);
endmodule // pio_board

// >>> pio_ports_test.sv
// testbench: reset values per mode, register access and pin behaviour of the i/o ports
module pio_ports_test;
    timeunit 1ns;
    timeprecision 1ps;
    import pio_pkg::*;

    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, mode_sel;
    logic [2:0]  hsize;
    logic [7:0]  port1_in, port2_in, port3_pullup_en, ext1, ext2;
    pio_drive_t  port1_drive, port2_drive;
    int          err_count, samples_checked;

    pio_ports pio_ports_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mode_sel(mode_sel),
        .port1_in(port1_in), .port1_drive(port1_drive), .port2_in(port2_in),
        .port2_drive(port2_drive), .port3_pullup_en(port3_pullup_en));
    pio_board pio_board_i (.drive1(port1_drive), .drive2(port2_drive), .ext1(ext1),
        .ext2(ext2), .pin1(port1_in), .pin2(port2_in));

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] pin_exp(input logic [7:0] d, l, e);
        return (d & l) | (~d & e);
    endfunction

    // ----------------------------------------------------------------
    // bus master: single word transfers, waits on hready only
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [31:0] rdv);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= PIO_HTRANS_NONSEQ;
        hwrite <= wr;
        haddr  <= {22'h000000, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h000000, wd};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rdv = hrdata;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] r;
        xfer(1'b1, idx, wd, r);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, idx, 8'h00, r);
        chk(r, exp);
        chk(hresp, 1'b0);
    endtask

    task automatic do_reset(input logic [1:0] m, input int n);
        hresetn  <= 1'b0;
        mode_sel <= m;
        repeat (n) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
    endtask

    // one round of writes, then drive, pin and read-back checks
    task automatic step(input bit locked, input logic [7:0] d1, d2, l1, l2, pu);
        ext1 <= 8'($urandom);
        ext2 <= 8'($urandom);
        wr(PIO_IDX_P1_DIR, d1);
        wr(PIO_IDX_P2_DIR, d2);
        wr(PIO_IDX_P1_LATCH, l1);
        wr(PIO_IDX_P2_LATCH, l2);
        wr(PIO_IDX_P3_PULL, pu);
        wr(8'ha0, 8'h5a);
        // a locked port drives every pin whatever was written to its direction
        if (locked)
        begin
            d1 = PIO_RST_DIR_HIGH;
            d2 = PIO_RST_DIR_HIGH;
        end
        repeat (2) @(posedge hclk);
        chk(port1_drive.oe, d1);
        chk(port2_drive.oe, d2);
        chk(port1_drive.out, l1 & d1);
        chk(port2_drive.out, l2 & d2);
        chk(port3_pullup_en, pu);
        rdc(PIO_IDX_P1_LATCH, {24'h0, l1});
        rdc(PIO_IDX_P2_LATCH, {24'h0, l2});
        rdc(PIO_IDX_P3_PULL, {24'h0, pu});
        rdc(PIO_IDX_P2_DIR, {24'h0, PIO_RD_WO});
        rdc(8'ha0, PIO_RD_NONE);
        rdc(PIO_IDX_P1_PINS, {24'h0, pin_exp(d1, l1, ext1)});
        rdc(PIO_IDX_P2_PINS, {24'h0, pin_exp(d2, l2, ext2)});
    endtask

    // ----------------------------------------------------------------
    // clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial
    begin
        #(40 * 20000);
        err_count++;
        complete_run();
    end

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        mode_sel = 2'h0;
        ext1 = 8'h00;
        ext2 = 8'h00;
        err_count = 0;
        samples_checked = 0;
        void'($urandom(24677));
        for (int m = 0; m < 4; m++)
        begin
            do_reset(m[1:0], (m == 0) ? 20 : 2);
            chk(port1_drive.oe, (m == 1) ? PIO_RST_DIR_HIGH : PIO_RST_DIR_LOW);
            chk(port2_drive.oe, (m == 1) ? PIO_RST_DIR_HIGH : PIO_RST_DIR_LOW);
            chk(port1_drive.out, PIO_RST_LATCH);
            chk(port2_drive.out, PIO_RST_LATCH);
            chk(port3_pullup_en, PIO_RST_PULL);
            rdc(PIO_IDX_P1_LATCH, {24'h0, PIO_RST_LATCH});
            rdc(PIO_IDX_P2_LATCH, {24'h0, PIO_RST_LATCH});
            rdc(PIO_IDX_P3_PULL, {24'h0, PIO_RST_PULL});
            rdc(PIO_IDX_P1_DIR, {24'h0, PIO_RD_WO});
            rdc(PIO_IDX_MODE, m);
            step(m == 1, 8'h00, 8'hff, 8'hff, 8'h00, 8'hff);
            step(m == 1, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00);
            repeat (6)
                step(m == 1, 8'($urandom), 8'($urandom), 8'($urandom), 8'($urandom),
                     8'($urandom));
        end
        complete_run();
    end
endmodule // pio_ports_test
